// File: inc/phy_regs_consts.svh
// Address map, field positions, reset values and masks of the PHY register bank.
// Assumes inclusion by its bare name from package and design files.
`ifndef PHY_REGS_CONSTS_SVH
`define PHY_REGS_CONSTS_SVH

`define PHY_ADDR_W 8
`define PHY_REG_W 16
`define PHY_IDX_LO 2
`define PHY_IDX_HI 4
`define PHY_IDX_CTRL 3'h0
`define PHY_IDX_STAT 3'h1
`define PHY_IDX_TWO 3'h2
`define PHY_IDX_THREE 3'h3
`define PHY_IDX_FOUR 3'h4
`define PHY_IDX_FIVE 3'h5
`define PHY_IDX_SIX 3'h6

`define CTRL_RST_VAL 16'h1000
`define CTRL_WR_MASK 16'hFF00
`define CTRL_PHY_RST_BIT 15
`define CTRL_RESTART_BIT 9
`define CTRL_AUTONEG_BIT 12

`define STAT_RO_MASK 16'hFE69
`define STAT_LH0_BIT 1
`define STAT_LL_BIT 2
`define STAT_LH1_BIT 4

`define CFG_RST_VAL 16'h0000
`define HW_FIELD_W 8
`define EV_W 8
`define EV_HALF 4
`define NIBBLE_W 4
`define ZERO_WORD 16'h0000
`define BUS_HI_ZERO 16'h0000

`endif

// File: inc/phy_regs_pkg.sv
// Types shared by the PHY register bank.
// Assumes phy_regs_consts.svh on the include path.
`include "phy_regs_consts.svh"

package phy_regs_pkg;

	typedef logic [`PHY_REG_W-1:0] word_type;
	typedef logic [2:0] idx_type;
	typedef logic [`EV_W-1:0] ev_type;

endpackage

// File: logic/phy_register_access_fabric.sv
// PHY register bank: seven 16-bit words behind an APB slave, built from the access types.
// Assumes APB master on REF_CLK, synchronous status inputs, synchronous reset RST.
//
// Notes on behaviour
// - Word indices 0 to 6 decode one register each; whole words only.
// - Read-only status is flopped from its source, one clock behind.
// - Software writes to hardware-written read fields change nothing.
// - Read/write fields store writes, read back and drive hardware.
// - Virtual read fields have no flop; live input goes to read mux.
// - Latch-high sets on high source, holds until read; read clears unless high.
// - Latch-low captures a low source, holds until a read clears it.
// - Latch-high mask field clears where a written mask bit is 1.
// - Latch-low mask field clears by mask write, not by read.
// - Interrupt-high field sets on rising source, clears on read.
// - Interrupt-low field sets on falling source, clears on read.
// - Interrupt mask fields capture an edge, clear only by mask write.
// - Interrupt enables are read/write; only enabled sources raise the request.
// - Latch-on-reset field loads its input first clock after reset.
// - Self-clearing write gives a one-clock strobe, then clears itself.
// - Hardware-affected field: software write wins over hardware load.
// - Write-only field passes the written value to hardware.
`timescale 1ns/1ns
`include "phy_regs_consts.svh"

module phy_register_access_fabric
	import phy_regs_pkg::*;
#(
	parameter int ADDR_W = `PHY_ADDR_W,
	parameter int REG_W = `PHY_REG_W
) (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic STRAP_IN,
	input wire logic [REG_W-1:0] STATUS_IN,
	input wire logic [1:0] LH_SRC,
	input wire logic LL_SRC,
	input wire logic [REG_W-1:0] VIRT_A_IN,
	input wire logic [REG_W-1:0] VIRT_B_IN,
	input wire logic HW_LOAD,
	input wire logic [`HW_FIELD_W-1:0] HW_VALUE,
	input wire logic [REG_W-1:0] MK_SRC,
	input wire logic [`EV_W-1:0] EV_SRC,
	output logic [REG_W-1:0] CTRL_OUT,
	output logic [REG_W-1:0] CFG_OUT,
	output logic [REG_W-1:0] WO_OUT,
	output logic IRQ
);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	if (ADDR_W < `PHY_IDX_HI + 2) begin : g_bad_addr
		$error("ADDR_W too small for the word map");
	end
	if (REG_W != `PHY_REG_W) begin : g_bad_width
		$error("REG_W must be 16");
	end

	// ************************************************************
	// Bus decode
	// ************************************************************
	function automatic logic hit(input logic [ADDR_W-1:0] a, input idx_type i);
		hit = (a[ADDR_W-1:`PHY_IDX_HI+1] == '0) && (a[`PHY_IDX_HI:`PHY_IDX_LO] == i);
	endfunction

	logic setup_phase;
	logic wr_acc;
	logic rd_acc;
	logic boot_q;
	word_type wdata;
	word_type ctrl_q;
	word_type stat_q;
	logic [2:0] lat_q;
	logic [2:0] lat_set;
	logic [2:0] lat_clr;
	word_type cfg_q;
	word_type wo_q;
	word_type mk_q;
	word_type mk_prev_q;
	word_type mk_set;
	word_type mk_clr;
	ev_type ev_q;
	ev_type ev_prev_q;
	ev_type ev_set;
	ev_type ev_clr;
	ev_type ien_q;
	logic irq_q;
	word_type rmux;
	word_type prdata_q;

	assign setup_phase = PSEL && !PENABLE;
	assign wr_acc = PSEL && PENABLE && PWRITE;
	assign rd_acc = PSEL && PENABLE && !PWRITE;
	assign wdata = PWDATA[REG_W-1:0];
	assign PREADY = 1'b1;
	assign PSLVERR = 1'b0;
	assign PRDATA = {`BUS_HI_ZERO, prdata_q};

	// ************************************************************
	// Reset release marker
	// ************************************************************
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			boot_q <= 1'b0;
		end else begin
			boot_q <= 1'b1;
		end
	end

	// ************************************************************
	// Word 0: control
	// ************************************************************
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ctrl_q <= `CTRL_RST_VAL;
		end else begin
			ctrl_q[`CTRL_PHY_RST_BIT] <= 1'b0;
			ctrl_q[`CTRL_RESTART_BIT] <= 1'b0;
			if (wr_acc && hit(PADDR, `PHY_IDX_CTRL)) begin
				ctrl_q <= wdata & `CTRL_WR_MASK;
			end
			if (!boot_q) begin
				ctrl_q[`CTRL_AUTONEG_BIT] <= STRAP_IN;
			end
		end
	end
	assign CTRL_OUT = ctrl_q;

	// ************************************************************
	// Word 1: status
	// ************************************************************
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			stat_q <= `ZERO_WORD;
		end else begin
			stat_q <= STATUS_IN & `STAT_RO_MASK;
		end
	end

	assign lat_set = {LH_SRC[1], !LL_SRC, LH_SRC[0]};
	assign lat_clr = {3{rd_acc && hit(PADDR, `PHY_IDX_STAT)}}
		& {prdata_q[`STAT_LH1_BIT], prdata_q[`STAT_LL_BIT], prdata_q[`STAT_LH0_BIT]};

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			lat_q <= 3'h0;
		end else begin
			lat_q <= (lat_q & ~lat_clr) | lat_set;
		end
	end

	// ************************************************************
	// Word 3 write-only, word 4 configuration
	// ************************************************************
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			wo_q <= `ZERO_WORD;
		end else if (wr_acc && hit(PADDR, `PHY_IDX_THREE)) begin
			wo_q <= wdata;
		end
	end
	assign WO_OUT = wo_q;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			cfg_q <= `CFG_RST_VAL;
		end else if (wr_acc && hit(PADDR, `PHY_IDX_FOUR)) begin
			cfg_q <= wdata;
		end else if (HW_LOAD) begin
			cfg_q[`HW_FIELD_W-1:0] <= HW_VALUE;
		end
	end
	assign CFG_OUT = cfg_q;

	// ************************************************************
	// Word 5: mask-cleared latches and edges
	// ************************************************************
	for (genvar n = 0; n < `NIBBLE_W; n++) begin : g_mk
		localparam int LO = n * `NIBBLE_W;
		logic [`NIBBLE_W-1:0] s;
		logic [`NIBBLE_W-1:0] p;
		assign s = MK_SRC[LO +: `NIBBLE_W];
		assign p = mk_prev_q[LO +: `NIBBLE_W];
		if (n == 0) begin : g_lh
			assign mk_set[LO +: `NIBBLE_W] = s;
		end else if (n == 1) begin : g_ll
			assign mk_set[LO +: `NIBBLE_W] = ~s;
		end else if (n == 2) begin : g_ih
			assign mk_set[LO +: `NIBBLE_W] = s & ~p & {`NIBBLE_W{boot_q}};
		end else begin : g_il
			assign mk_set[LO +: `NIBBLE_W] = ~s & p & {`NIBBLE_W{boot_q}};
		end
	end

	assign mk_clr = (wr_acc && hit(PADDR, `PHY_IDX_FIVE)) ? wdata : `ZERO_WORD;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			mk_q <= `ZERO_WORD;
			mk_prev_q <= `ZERO_WORD;
		end else begin
			mk_q <= (mk_q & ~mk_clr) | mk_set;
			mk_prev_q <= MK_SRC;
		end
	end

	// ************************************************************
	// Word 6: read-cleared edges and enables
	// ************************************************************
	assign ev_set[`EV_HALF-1:0] = EV_SRC[`EV_HALF-1:0] & ~ev_prev_q[`EV_HALF-1:0]
		& {`EV_HALF{boot_q}};
	assign ev_set[`EV_W-1:`EV_HALF] = ~EV_SRC[`EV_W-1:`EV_HALF] & ev_prev_q[`EV_W-1:`EV_HALF]
		& {`EV_HALF{boot_q}};
	assign ev_clr = {`EV_W{rd_acc && hit(PADDR, `PHY_IDX_SIX)}} & prdata_q[`EV_W-1:0];

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ev_q <= '0;
			ev_prev_q <= '0;
		end else begin
			ev_q <= (ev_q & ~ev_clr) | ev_set;
			ev_prev_q <= EV_SRC;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ien_q <= '0;
		end else if (wr_acc && hit(PADDR, `PHY_IDX_SIX)) begin
			ien_q <= wdata[REG_W-1:`EV_W];
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(ev_q & ien_q);
		end
	end
	assign IRQ = irq_q;

	// ************************************************************
	// Read path
	// ************************************************************
	always_comb begin
		rmux = `ZERO_WORD;
		if (hit(PADDR, `PHY_IDX_CTRL)) begin
			rmux = ctrl_q;
		end else if (hit(PADDR, `PHY_IDX_STAT)) begin
			rmux = stat_q;
			rmux[`STAT_LH1_BIT] = lat_q[2];
			rmux[`STAT_LL_BIT] = lat_q[1];
			rmux[`STAT_LH0_BIT] = lat_q[0];
		end else if (hit(PADDR, `PHY_IDX_TWO)) begin
			rmux = VIRT_A_IN;
		end else if (hit(PADDR, `PHY_IDX_THREE)) begin
			rmux = VIRT_B_IN;
		end else if (hit(PADDR, `PHY_IDX_FOUR)) begin
			rmux = cfg_q;
		end else if (hit(PADDR, `PHY_IDX_FIVE)) begin
			rmux = mk_q;
		end else if (hit(PADDR, `PHY_IDX_SIX)) begin
			rmux = {ien_q, ev_q};
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			prdata_q <= `ZERO_WORD;
		end else if (setup_phase) begin
			prdata_q <= rmux;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RST);

	chk_status_sample: assert property (
		##1 stat_q == ($past(STATUS_IN) & `STAT_RO_MASK))
		else $error("status not sampled one clock behind");

	chk_cfg_store: assert property (
		wr_acc && hit(PADDR, `PHY_IDX_FOUR) |=> CFG_OUT == $past(wdata))
		else $error("config write not stored");

	chk_wo_store: assert property (
		wr_acc && hit(PADDR, `PHY_IDX_THREE) |=> WO_OUT == $past(wdata))
		else $error("write-only value not passed on");

	chk_latch_hold: assert property (
		lat_q[0] && !(rd_acc && hit(PADDR, `PHY_IDX_STAT)) |=> lat_q[0])
		else $error("latch-high bit dropped without read");

	chk_strobe_width: assert property (
		CTRL_OUT[`CTRL_PHY_RST_BIT] |=> !CTRL_OUT[`CTRL_PHY_RST_BIT])
		else $error("strobe longer than one clock");

	chk_strap_load: assert property (
		!boot_q |=> CTRL_OUT[`CTRL_AUTONEG_BIT] == $past(STRAP_IN))
		else $error("strap not loaded after reset");

	chk_rise_set: assert property (
		boot_q && EV_SRC[0] && !ev_prev_q[0] |=> ev_q[0])
		else $error("rising edge not captured");

	chk_irq_gate: assert property (
		(ev_q & ien_q) != '0 |=> IRQ ##0 ($past(ien_q) != '0))
		else $error("enabled event gave no request");

	chk_unmapped_read: assert property (
		setup_phase && PADDR[ADDR_W-1:`PHY_IDX_HI+1] != '0 ##1 rd_acc |-> PRDATA == '0)
		else $error("unmapped read not zero");

	chk_mask_clear: assert property (
		wr_acc && hit(PADDR, `PHY_IDX_FIVE) && wdata[0] && !MK_SRC[0] |=> !mk_q[0])
		else $error("mask write did not clear");

	chk_event_kept: assert property (
		ev_clr[0] && ev_set[0] |=> ev_q[0])
		else $error("event lost at clear");

	cov_read_clear: cover property (rd_acc && hit(PADDR, `PHY_IDX_SIX) && ev_q != '0);
	cov_mask_write: cover property (wr_acc && hit(PADDR, `PHY_IDX_FIVE) && mk_q != '0);
	cov_strobe: cover property (CTRL_OUT[`CTRL_RESTART_BIT]);
	cov_irq: cover property ($rose(IRQ));

endmodule

// File: testbench/apb_host_model.sv
// APB master standing in for the management controller.
// Assumes the slave shares clk; tasks are entered right after a rising edge.
`timescale 1ns/1ns
module apb_host_model (
	input wire logic clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'hFF;
		pwdata = 32'h0;
	end

	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {a[7:2], 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= ~wr;
		paddr <= ~a;
		pwdata <= ~wd;
	endtask
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the PHY register bank.
// Assumes a zero-wait APB slave; hardware sources are driven here directly.
`timescale 1ns/1ns
module tb_top
	import phy_regs_pkg::*;
;
	logic REF_CLK = 1'b0;
	logic RST = 1'b1;
	logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
	logic STRAP_IN = 1'b0, LL_SRC = 1'b1, HW_LOAD = 1'b0;
	logic [7:0] PADDR;
	logic [7:0] HW_VALUE = 8'h5A;
	logic [1:0] LH_SRC = 2'h0;
	logic [31:0] PWDATA, PRDATA;
	word_type STATUS_IN = 16'h0000, VIRT_A_IN = 16'hA5C3, VIRT_B_IN = 16'h3C5A;
	word_type MK_SRC = 16'h00F0;
	word_type CTRL_OUT, CFG_OUT, WO_OUT;
	ev_type EV_SRC = 8'hF0;
	int failures = 0, total_checks = 0, cycles = 0;

	always #25 REF_CLK = ~REF_CLK;

	phy_register_access_fabric phy_register_access_fabric_i (.REF_CLK(REF_CLK), .RST(RST),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .STRAP_IN(STRAP_IN),
		.STATUS_IN(STATUS_IN), .LH_SRC(LH_SRC), .LL_SRC(LL_SRC), .VIRT_A_IN(VIRT_A_IN),
		.VIRT_B_IN(VIRT_B_IN), .HW_LOAD(HW_LOAD), .HW_VALUE(HW_VALUE), .MK_SRC(MK_SRC),
		.EV_SRC(EV_SRC), .CTRL_OUT(CTRL_OUT), .CFG_OUT(CFG_OUT), .WO_OUT(WO_OUT), .IRQ(IRQ));

	apb_host_model apb_host_model_i (.clk(REF_CLK), .psel(PSEL), .penable(PENABLE),
		.pwrite(PWRITE), .paddr(PADDR), .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic end_of_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		apb_host_model_i.xfer(1'b0, a, 32'h0, d);
		chk($sformatf("read %h", a), e, d);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] d;
		apb_host_model_i.xfer(1'b1, a, v, d);
		#1;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_control;
		chk("ctrl", 32'h0, {16'h0, CTRL_OUT});
		rd(8'h00, 32'h0);
		wr(8'h00, 32'hFFFFFFFF);
		chk("ctrl", 32'hFF00, {16'h0, CTRL_OUT});
		@(posedge REF_CLK);
		#1;
		chk("ctrl", 32'h7D00, {16'h0, CTRL_OUT});
		rd(8'h00, 32'h7D00);
		$display("test control done");
	endtask

	task automatic t_status;
		STATUS_IN <= 16'hFFFF;
		rd(8'h04, 32'hFE69);
		wr(8'h04, 32'h0);
		rd(8'h04, 32'hFE69);
		STATUS_IN <= 16'h0;
		LH_SRC <= 2'h1;
		LL_SRC <= 1'b0;
		@(posedge REF_CLK);
		LH_SRC <= 2'h0;
		LL_SRC <= 1'b1;
		rd(8'h04, 32'h6);
		rd(8'h04, 32'h0);
		$display("test status done");
	endtask

	task automatic t_config;
		wr(8'h10, 32'h1234);
		chk("cfg", 32'h1234, {16'h0, CFG_OUT});
		rd(8'h10, 32'h1234);
		HW_LOAD <= 1'b1;
		wr(8'h10, 32'hBEEF);
		chk("cfg", 32'hBEEF, {16'h0, CFG_OUT});
		@(posedge REF_CLK);
		HW_LOAD <= 1'b0;
		@(posedge REF_CLK);
		#1;
		chk("cfg", 32'hBE5A, {16'h0, CFG_OUT});
		wr(8'h30, 32'h0);
		wr(8'h1C, 32'h0);
		chk("cfg", 32'hBE5A, {16'h0, CFG_OUT});
		chk("slverr", 32'h0, {31'h0, PSLVERR});
		rd(8'h1C, 32'h0);
		rd(8'h20, 32'h0);
		$display("test config done");
	endtask

	task automatic t_virtual;
		rd(8'h08, 32'hA5C3);
		VIRT_A_IN <= 16'h0F0F;
		rd(8'h08, 32'h0F0F);
		wr(8'h0C, 32'h7E81);
		chk("wo", 32'h7E81, {16'h0, WO_OUT});
		rd(8'h0C, 32'h3C5A);
		wr(8'h08, 32'hFFFF);
		rd(8'h08, 32'h0F0F);
		$display("test virtual done");
	endtask

	task automatic t_mask;
		MK_SRC <= 16'h1101;
		@(posedge REF_CLK);
		MK_SRC <= 16'h00F0;
		rd(8'h14, 32'h11F1);
		rd(8'h14, 32'h11F1);
		wr(8'h14, 32'h0110);
		rd(8'h14, 32'h10E1);
		wr(8'h14, 32'hFFFF);
		rd(8'h14, 32'h0);
		$display("test mask done");
	endtask

	task automatic t_events;
		wr(8'h18, 32'h0100);
		@(posedge REF_CLK);
		EV_SRC <= 8'h01;
		@(posedge REF_CLK);
		EV_SRC <= 8'hF0;
		repeat (2) @(posedge REF_CLK);
		#1;
		chk("irq", 32'h1, {31'h0, IRQ});
		rd(8'h18, 32'h01F1);
		rd(8'h18, 32'h0100);
		wr(8'h18, 32'h1000);
		@(posedge REF_CLK);
		EV_SRC <= 8'hF1;
		repeat (3) @(posedge REF_CLK);
		#1;
		chk("irq", 32'h0, {31'h0, IRQ});
		rd(8'h18, 32'h1001);
		EV_SRC <= 8'hF0;
		@(posedge REF_CLK);
		EV_SRC <= 8'hF1;
		@(posedge REF_CLK);
		EV_SRC <= 8'hF0;
		fork
			rd(8'h18, 32'h1001);
			begin
				repeat (2) @(posedge REF_CLK);
				EV_SRC <= 8'hF1;
			end
		join
		rd(8'h18, 32'h1001);
		rd(8'h18, 32'h1000);
		$display("test events done");
	endtask

	task automatic t_reset;
		STRAP_IN <= 1'b1;
		RST <= 1'b1;
		repeat (3) @(posedge REF_CLK);
		RST <= 1'b0;
		@(posedge REF_CLK);
		STRAP_IN <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		chk("ctrl", 32'h1000, {16'h0, CTRL_OUT});
		chk("irq", 32'h0, {31'h0, IRQ});
		rd(8'h00, 32'h1000);
		rd(8'h18, 32'h0000);
		$display("test reset done");
	endtask

	always @(posedge REF_CLK) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			end_of_test();
		end
	end

	initial begin
		repeat (5) @(posedge REF_CLK);
		#1;
		chk("ctrl", 32'h1000, {16'h0, CTRL_OUT});
		repeat (5) @(posedge REF_CLK);
		RST <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		t_control();
		t_status();
		t_config();
		t_virtual();
		t_mask();
		t_events();
		t_reset();
		end_of_test();
	end
endmodule
